// [rtl/fsr_ctl.v]
/*
 * Serial flash command front end: pin sampling, opcode decode, status
 * register with write cycle timer, read data path with a small FIFO.
 * Assumes the array answers a fetch within two clocks and that the
 * serial clock is slow enough to give at least eight clocks per bit.
 */
`timescale 1ns/1ns
`include "fsr_regs.vh"

// ----------------------------------------------------------------
// Data FIFO
// ----------------------------------------------------------------
module fsr_fifo #(
    parameter WIDTH = `FSR_FIFO_WIDTH,
    parameter DEPTH = `FSR_FIFO_DEPTH,
    parameter AW = 2
) (
    input wire clk_i,
    input wire reset_i,
    input wire flush_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    // Handshakes on both sides.
    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Storage array, written on each accepted word.
    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and fill count; flush empties the buffer.
    always @(posedge clk_i) begin
        if (reset_i || flush_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------------------------------
// Command front end
// ----------------------------------------------------------------
module fsr_ctl #(
    parameter TW_CYCLES = `FSR_TW_US * `FSR_CLK_MHZ
) (
    input wire clk_i,
    input wire reset_i,
    input wire cs_n_i,
    input wire sclk_i,
    input wire [3:0] io_i,
    output reg [3:0] io_o,
    output reg [3:0] io_oe_o,
    input wire quad_mode_i,
    input wire [1:0] dummy_count_i,
    input wire ext_busy_i,
    input wire ext_done_i,
    output reg [15:0] status_o,
    output reg mem_req_o,
    output reg [23:0] mem_addr_o,
    input wire mem_valid_i,
    input wire [7:0] mem_data_i
);
    localparam ST_OPC = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_DUMMY = 3'd2;
    localparam ST_WDATA = 3'd3;
    localparam ST_STAT = 3'd4;
    localparam ST_READ = 3'd5;
    localparam ST_IGNORE = 3'd6;

    reg cs_n_s0;
    reg cs_n_s1;
    reg cs_n_d;
    reg sclk_s0;
    reg sclk_s1;
    reg sclk_d;
    reg [3:0] io_s0;
    reg [3:0] io_s1;
    reg [2:0] state;
    reg [3:0] bcnt;
    reg [2:0] nbytes;
    reg [1:0] dbytes;
    reg [7:0] opcode;
    reg [7:0] shift_in;
    reg [23:0] addr;
    reg [3:0] dcnt;
    reg vol_armed;
    reg vol_this;
    reg [15:0] wsr_data;
    reg [7:0] out_sh;
    reg [3:0] obits;
    reg fetch_on;
    reg pending;
    reg [23:0] fetch_addr;
    reg wsr_busy;
    reg [23:0] tw_cnt;
    reg [15:0] wsr_val;
    reg [7:0] obyte;

    wire sck_rise;
    wire sck_fall;
    wire cs_act;
    wire cs_rise;
    wire [3:0] step;
    wire [7:0] next_byte;
    wire byte_done;
    wire write_in_progress;
    wire write_enable_latch;
    wire short_frame;
    wire wsr_go;
    wire wsr_end;
    wire fifo_ready;
    wire fifo_valid;
    wire [7:0] fifo_data;
    wire fifo_pop;
    wire out_state;

    // Dummy clock count in quad mode from the read parameter field.
    function [3:0] quad_dummy;
        input [1:0] field;
        begin
            case (field)
                2'h0: quad_dummy = `FSR_QDUMMY_0;
                2'h1: quad_dummy = `FSR_QDUMMY_1;
                2'h2: quad_dummy = `FSR_QDUMMY_2;
                default: quad_dummy = `FSR_QDUMMY_3;
            endcase
        end
    endfunction

    // Two-stage synchronisers for the pins, plus edge history.
    always @(posedge clk_i) begin
        if (reset_i) begin
            cs_n_s0 <= 1'b1;
            cs_n_s1 <= 1'b1;
            cs_n_d <= 1'b1;
            sclk_s0 <= 1'b0;
            sclk_s1 <= 1'b0;
            sclk_d <= 1'b0;
            io_s0 <= 4'h0;
            io_s1 <= 4'h0;
        end else begin
            cs_n_s0 <= cs_n_i;
            cs_n_s1 <= cs_n_s0;
            cs_n_d <= cs_n_s1;
            sclk_s0 <= sclk_i;
            sclk_s1 <= sclk_s0;
            sclk_d <= sclk_s1;
            io_s0 <= io_i;
            io_s1 <= io_s0;
        end
    end

    // Edge detection and shift helpers.
    assign cs_act = ~cs_n_s1;
    assign cs_rise = cs_n_s1 & ~cs_n_d;
    assign sck_rise = cs_act & sclk_s1 & ~sclk_d;
    assign sck_fall = cs_act & ~sclk_s1 & sclk_d;
    assign step = quad_mode_i ? 4'h4 : 4'h1;
    assign next_byte = quad_mode_i ? {shift_in[3:0], io_s1}
                                   : {shift_in[6:0], io_s1[0]};
    assign byte_done = ((bcnt + step) == 4'h8);
    assign write_in_progress = status_o[`FSR_BIT_BUSY];
    assign write_enable_latch = status_o[`FSR_BIT_WEL];
    assign short_frame = (state == ST_IGNORE) && (nbytes == 3'd0) &&
                         (bcnt == 4'h0);
    assign out_state = (state == ST_STAT) || (state == ST_READ);

    // A status write counts only if select rose on a byte boundary.
    assign wsr_go = cs_rise && (state == ST_WDATA) && (bcnt == 4'h0) &&
                    ((dbytes == 2'd1) || (dbytes == 2'd2)) &&
                    !write_in_progress && (write_enable_latch || vol_this);
    assign wsr_end = wsr_busy && (tw_cnt == 24'h000001);

    // Command sequencer, advanced on synchronised serial clock rises.
    always @(posedge clk_i) begin
        if (reset_i) begin
            state <= ST_OPC;
            bcnt <= 4'h0;
            nbytes <= 3'd0;
            dbytes <= 2'd0;
            opcode <= 8'h00;
            shift_in <= 8'h00;
            addr <= 24'h000000;
            dcnt <= 4'h0;
            vol_armed <= 1'b0;
            vol_this <= 1'b0;
            wsr_data <= 16'h0000;
        end else if (cs_rise) begin
            state <= ST_OPC;
            bcnt <= 4'h0;
            nbytes <= 3'd0;
            dbytes <= 2'd0;
            if (short_frame && (opcode == `FSR_OP_VOL_ENA)) begin
                vol_armed <= 1'b1;
            end
        end else if (sck_rise) begin
            shift_in <= next_byte;
            bcnt <= byte_done ? 4'h0 : (bcnt + step);
            if (state == ST_DUMMY) begin
                dcnt <= dcnt - 1'b1;
                if (dcnt == 4'h1) begin
                    state <= ST_READ;
                end
            end else if (byte_done) begin
                case (state)
                    ST_OPC: begin
                        opcode <= next_byte;
                        vol_armed <= 1'b0;
                        vol_this <= vol_armed &&
                                    (next_byte == `FSR_OP_STAT_WR);
                        if ((next_byte == `FSR_OP_STAT_LO) ||
                            (next_byte == `FSR_OP_STAT_HI)) begin
                            state <= ST_STAT;
                        end else if (next_byte == `FSR_OP_READ) begin
                            state <= write_in_progress ? ST_IGNORE : ST_ADDR;
                        end else if (next_byte == `FSR_OP_FAST) begin
                            state <= ST_ADDR;
                        end else if (next_byte == `FSR_OP_STAT_WR) begin
                            state <= ST_WDATA;
                        end else begin
                            state <= ST_IGNORE;
                        end
                    end
                    ST_ADDR: begin
                        addr <= {addr[15:0], next_byte};
                        nbytes <= nbytes + 1'b1;
                        if (nbytes == 3'd2) begin
                            if (opcode == `FSR_OP_FAST) begin
                                state <= ST_DUMMY;
                                dcnt <= quad_mode_i ?
                                        quad_dummy(dummy_count_i) :
                                        `FSR_SPI_DUMMY;
                            end else begin
                                state <= ST_READ;
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (dbytes == 2'd0) begin
                            wsr_data[7:0] <= next_byte;
                        end else if (dbytes == 2'd1) begin
                            wsr_data[15:8] <= next_byte;
                        end
                        if (dbytes != 2'd3) begin
                            dbytes <= dbytes + 1'b1;
                        end
                    end
                    default: begin
                        if (nbytes != 3'd7) begin
                            nbytes <= nbytes + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // Value a status write would produce from the supplied data.
    always @* begin
        wsr_val = {(dbytes == 2'd2) ? wsr_data[15:8] : status_o[15:8],
                   wsr_data[7:0]};
        wsr_val = (wsr_val & `FSR_WR_MASK) |
                  (status_o & ~`FSR_WR_MASK);
        if (dbytes == 2'd1) begin
            wsr_val[`FSR_BIT_CMP] = 1'b0;
        end
    end

    // Status register, write cycle timer and latch bookkeeping.
    always @(posedge clk_i) begin
        if (reset_i) begin
            status_o <= `FSR_STATUS_RST;
            wsr_busy <= 1'b0;
            tw_cnt <= 24'h000000;
        end else begin
            if (wsr_go) begin
                status_o[15:2] <= wsr_val[15:2];
            end
            if (wsr_go && !vol_this) begin
                wsr_busy <= 1'b1;
                tw_cnt <= TW_CYCLES[23:0];
            end else if (wsr_busy) begin
                tw_cnt <= tw_cnt - 1'b1;
                if (wsr_end) begin
                    wsr_busy <= 1'b0;
                end
            end
            status_o[`FSR_BIT_BUSY] <= (wsr_busy && !wsr_end) ||
                                       (wsr_go && !vol_this) ||
                                       ext_busy_i;
            if (cs_rise && short_frame && (opcode == `FSR_OP_WR_ENA)) begin
                status_o[`FSR_BIT_WEL] <= 1'b1;
            end else if (cs_rise && short_frame && !write_in_progress &&
                         (opcode == `FSR_OP_WR_DIS)) begin
                status_o[`FSR_BIT_WEL] <= 1'b0;
            end else if (wsr_end || ext_done_i) begin
                status_o[`FSR_BIT_WEL] <= 1'b0;
            end
        end
    end

    // Array fetch engine: one request outstanding, FIFO space gated.
    always @(posedge clk_i) begin
        if (reset_i) begin
            fetch_on <= 1'b0;
            pending <= 1'b0;
            fetch_addr <= 24'h000000;
            mem_req_o <= 1'b0;
            mem_addr_o <= 24'h000000;
        end else begin
            mem_req_o <= 1'b0;
            if (mem_valid_i) begin
                pending <= 1'b0;
            end
            if (cs_rise) begin
                fetch_on <= 1'b0;
            end else if (sck_rise && byte_done && (state == ST_ADDR) &&
                         (nbytes == 3'd2) && (opcode == `FSR_OP_READ)) begin
                // The first fetch goes out at once, so a slow array
                // still has its first byte buffered before the first falling edge.
                fetch_on <= 1'b1;
                mem_req_o <= 1'b1;
                mem_addr_o <= {addr[15:0], next_byte};
                pending <= 1'b1;
                fetch_addr <= {addr[15:0], next_byte} + 24'h000001;
            end else if (sck_rise && (state == ST_DUMMY) &&
                         (dcnt == 4'h1)) begin
                fetch_on <= 1'b1;
                mem_req_o <= 1'b1;
                mem_addr_o <= addr;
                pending <= 1'b1;
                fetch_addr <= addr + 24'h000001;
            end else if (fetch_on && !pending && !mem_req_o &&
                         fifo_ready) begin
                mem_req_o <= 1'b1;
                mem_addr_o <= fetch_addr;
                pending <= 1'b1;
                fetch_addr <= fetch_addr + 24'h000001;
            end
        end
    end

    // Buffer between the array and the serial output.
    fsr_fifo #(
        .WIDTH(`FSR_FIFO_WIDTH),
        .DEPTH(`FSR_FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .flush_i(cs_rise),
        .in_valid_i(mem_valid_i & fetch_on),
        .in_ready_o(fifo_ready),
        .in_data_i(mem_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    // Byte to start on the next falling edge.
    assign fifo_pop = sck_fall && (state == ST_READ) && (obits == 4'h0);

    always @* begin
        if (state == ST_STAT) begin
            obyte = (opcode == `FSR_OP_STAT_HI) ? status_o[15:8]
                                                : status_o[7:0];
        end else begin
            obyte = fifo_valid ? fifo_data : 8'h00;
        end
    end

    // Serial output on falling edges, most significant part first.
    always @(posedge clk_i) begin
        if (reset_i) begin
            out_sh <= 8'h00;
            obits <= 4'h0;
            io_o <= 4'h0;
            io_oe_o <= 4'h0;
        end else begin
            if (cs_act && out_state) begin
                io_oe_o <= quad_mode_i ? 4'hF : 4'h2;
            end else begin
                io_oe_o <= 4'h0;
            end
            if (cs_rise) begin
                obits <= 4'h0;
            end else if (sck_fall && out_state) begin
                if (obits == 4'h0) begin
                    if (quad_mode_i) begin
                        io_o <= obyte[7:4];
                        out_sh <= {obyte[3:0], 4'h0};
                    end else begin
                        io_o <= {2'b00, obyte[7], 1'b0};
                        out_sh <= {obyte[6:0], 1'b0};
                    end
                    obits <= 4'h8 - step;
                end else begin
                    if (quad_mode_i) begin
                        io_o <= out_sh[7:4];
                        out_sh <= {out_sh[3:0], 4'h0};
                    end else begin
                        io_o <= {2'b00, out_sh[7], 1'b0};
                        out_sh <= {out_sh[6:0], 1'b0};
                    end
                    obits <= obits - step;
                end
            end
        end
    end
endmodule

// [rtl/fsr_regs.vh]
/*
 * Constants of the serial flash command front end: opcodes, status
 * field positions, reset values, dummy counts and timing figures.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef FSR_REGS_VH
`define FSR_REGS_VH
`define FSR_OP_WR_ENA 8'h06
`define FSR_OP_WR_DIS 8'h04
`define FSR_OP_STAT_LO 8'h05
`define FSR_OP_STAT_HI 8'h35
`define FSR_OP_STAT_WR 8'h01
`define FSR_OP_VOL_ENA 8'h50
`define FSR_OP_READ 8'h03
`define FSR_OP_FAST 8'h0B
`define FSR_BIT_BUSY 0
`define FSR_BIT_WEL 1
`define FSR_BIT_CMP 14
`define FSR_WR_MASK 16'h79FC
`define FSR_STATUS_RST 16'h0000
`define FSR_SPI_DUMMY 4'h8
`define FSR_QDUMMY_0 4'h4
`define FSR_QDUMMY_1 4'h4
`define FSR_QDUMMY_2 4'h6
`define FSR_QDUMMY_3 4'h8
`define FSR_CLK_MHZ 250
`define FSR_TW_US 2000
`define FSR_FIFO_WIDTH 8
`define FSR_FIFO_DEPTH 4
`endif

// [sim/fsr_ctl_assertions.sv]
/* Checker for the serial flash command front end, bound to fsr_ctl.
   Assumes one clock domain and a serial clock far slower than clk_i. */
`timescale 1ns/1ns
module fsr_ctl_assertions #(
    parameter TW_CYCLES = 20
) (
    input wire clk_i,
    input wire reset_i,
    input wire cs_n_i,
    input wire quad_mode_i,
    input wire ext_busy_i,
    input wire ext_done_i,
    input wire [3:0] io_oe_o,
    input wire [15:0] status_o,
    input wire mem_req_o,
    input wire [23:0] mem_addr_o
);
    // ------------------------------------------------
    // Helper logic
    // ------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    logic [31:0] bcnt;
    logic bext;
    logic [23:0] last_addr;
    logic in_frame;
    // Times each busy spell and notes whether the outside made it.
    always @(posedge clk_i) begin
        if (reset_i || !status_o[0]) begin
            bcnt <= 32'h0;
            bext <= 1'b0;
        end else begin
            bcnt <= bcnt + 32'h1;
            bext <= bext | ext_busy_i;
        end
    end
    // Keeps the last fetch address of the current select.
    always @(posedge clk_i) begin
        if (reset_i || cs_n_i) begin
            in_frame <= 1'b0;
        end else if (mem_req_o) begin
            in_frame <= 1'b1;
            last_addr <= mem_addr_o;
        end
    end
    sequence s_wr_start;
        $rose(status_o[0]) && !ext_busy_i;
    endsequence
    sequence s_wr_end;
        $fell(status_o[0]) && !bext && !$past(ext_busy_i);
    endsequence
    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    a_busy_len: assert property (
        s_wr_end |-> (bcnt == TW_CYCLES - 1 || bcnt == TW_CYCLES))
        else $error("write cycle length wrong");
    a_end_clears: assert property (
        s_wr_end |-> !status_o[1])
        else $error("latch kept after write cycle");
    a_wr_needs_latch: assert property (
        s_wr_start |-> status_o[1])
        else $error("write cycle began without latch");
    a_latch_held: assert property (
        status_o[0] && $past(status_o[0]) && $past(status_o[1])
        && !$past(ext_done_i) |-> status_o[1])
        else $error("latch lost during write cycle");
    a_done_clears: assert property (
        ext_done_i && cs_n_i && $past(cs_n_i, 8) |-> ##[1:2] !status_o[1])
        else $error("latch kept after outside completion");
    a_oe_idle: assert property (
        cs_n_i [*5] |-> io_oe_o == 4'h0)
        else $error("pins driven while deselected");
    a_oe_mode: assert property (
        io_oe_o != 4'h0 |-> io_oe_o == (quad_mode_i ? 4'hF : 4'h2))
        else $error("wrong pins driven");
    a_busy_cause: assert property (
        $rose(status_o[0]) |-> cs_n_i || ext_busy_i)
        else $error("busy began inside a frame");
    a_fixed_bits: assert property (
        $stable({status_o[15], status_o[10:9]}))
        else $error("fixed status bits changed");
    a_status_quiet: assert property (
        $changed(status_o[14:2]) |-> cs_n_i)
        else $error("status changed inside a frame");
    a_addr_next: assert property (
        mem_req_o && in_frame |-> mem_addr_o == last_addr + 24'h1)
        else $error("fetch address not incremented");
endmodule

bind fsr_ctl fsr_ctl_assertions #(.TW_CYCLES(TW_CYCLES))
    fsr_ctl_assertions_inst (.clk_i(clk_i), .reset_i(reset_i),
    .cs_n_i(cs_n_i), .quad_mode_i(quad_mode_i), .ext_busy_i(ext_busy_i),
    .ext_done_i(ext_done_i), .io_oe_o(io_oe_o), .status_o(status_o),
    .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o));

// [sim/fsr_host.sv]
/* Host serial controller model: select, serial clock and data lines.
   Assumes the bench calls its tasks and feeds back the device pins. */
`timescale 1ns/1ns
module fsr_host (
    input wire clk_i,
    input wire quad_i,
    input wire [3:0] dout_i,
    input wire [3:0] oe_i,
    output logic cs_n_o,
    output logic sclk_o,
    output wire [3:0] io_o
);
    logic [3:0] io_d = 4'h0;
    logic drv = 1'b1;
    logic oe_seen = 1'b0;
    logic cs_q = 1'b1;
    wire [3:0] line = (oe_i & dout_i) | (~oe_i & io_o);
    // Released lines show the inverse of the last value driven.
    assign io_o = drv ? io_d : ~io_d;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
    end
    // Notes any output drive since select last fell.
    always @(posedge clk_i) begin
        cs_q <= cs_n_o;
        if (cs_q && !cs_n_o) oe_seen <= 1'b0;
        else if (oe_i != 4'h0) oe_seen <= 1'b1;
    end
    // One serial clock of eight clk_i: fall, data out, rise, sample.
    task cyc(input logic [3:0] d, output logic [3:0] q);
        @(negedge clk_i);
        sclk_o = 1'b0;
        io_d = d;
        repeat (4) @(negedge clk_i);
        sclk_o = 1'b1;
        q = line;
        repeat (3) @(negedge clk_i);
    endtask
    task xbyte(input logic [7:0] b, input logic d, output logic [7:0] r);
        logic [3:0] q;
        drv = d;
        if (quad_i) begin
            cyc(b[7:4], q);
            r[7:4] = q;
            cyc(b[3:0], q);
            r[3:0] = q;
        end else begin
            for (int i = 7; i >= 0; i--) begin
                cyc({3'h0, b[i]}, q);
                r[i] = q[1];
            end
        end
    endtask
    task clocks(input int n);
        logic [3:0] q;
        drv = 1'b0;
        for (int i = 0; i < n; i++) cyc(4'h0, q);
    endtask
    task sel();
        @(negedge clk_i);
        drv = 1'b1;
        cs_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
    // Select rises only on a whole byte, then a quiet gap follows.
    task desel();
        @(negedge clk_i);
        sclk_o = 1'b0;
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        repeat (12) @(negedge clk_i);
    endtask
endmodule

// [sim/tb_top.sv]
/* Bench for the command front end: host model on the serial pins and
   an array model on the fetch port. Assumes fsr_ctl and fsr_host. */
`timescale 1ns/1ns
module tb_top;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic quad_mode_i = 1'b0;
    logic [1:0] dummy_count_i = 2'h0;
    logic ext_busy_i = 1'b0;
    logic ext_done_i = 1'b0;
    logic mem_valid_i = 1'b0;
    logic [7:0] mem_data_i = 8'h00;
    logic v1 = 1'b0;
    logic slow = 1'b0;
    logic [7:0] r;
    wire cs_n, sclk, mem_req;
    wire [3:0] io_in, io_out, io_oe;
    wire [15:0] status;
    wire [23:0] mem_addr;
    int fail_count = 0;
    int n_checks = 0;
    int dtab[4] = '{4, 4, 6, 8};
    fsr_ctl #(.TW_CYCLES(400)) fsr_ctl_inst (.clk_i(clk_i),
        .reset_i(reset_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io_in),
        .io_o(io_out), .io_oe_o(io_oe), .quad_mode_i(quad_mode_i),
        .dummy_count_i(dummy_count_i), .ext_busy_i(ext_busy_i),
        .ext_done_i(ext_done_i), .status_o(status), .mem_req_o(mem_req),
        .mem_addr_o(mem_addr), .mem_valid_i(mem_valid_i),
        .mem_data_i(mem_data_i));
    fsr_host fsr_host_inst (.clk_i(clk_i), .quad_i(quad_mode_i),
        .dout_i(io_out), .oe_i(io_oe), .cs_n_o(cs_n), .sclk_o(sclk),
        .io_o(io_in));
    always #2 clk_i = ~clk_i;
    // Array answers one or two clocks after a fetch; byte is addr^A5.
    always @(posedge clk_i) begin
        v1 <= mem_req;
        mem_valid_i <= slow ? v1 : mem_req;
        mem_data_i <= mem_addr[7:0] ^ 8'hA5;
    end
    task check(input string name, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task send(input logic [7:0] op);
        fsr_host_inst.sel();
        fsr_host_inst.xbyte(op, 1'b1, r);
        fsr_host_inst.desel();
    endtask
    // Status write with n data bytes; a third byte spoils the count.
    task swr(input int n, input logic [15:0] v);
        fsr_host_inst.sel();
        fsr_host_inst.xbyte(8'h01, 1'b1, r);
        if (n > 0) fsr_host_inst.xbyte(v[7:0], 1'b1, r);
        if (n > 1) fsr_host_inst.xbyte(v[15:8], 1'b1, r);
        if (n > 2) fsr_host_inst.xbyte(8'h00, 1'b1, r);
        fsr_host_inst.desel();
    endtask
    task rd(input logic [7:0] op, input logic [23:0] a);
        fsr_host_inst.sel();
        fsr_host_inst.xbyte(op, 1'b1, r);
        for (int i = 2; i >= 0; i--) fsr_host_inst.xbyte(a[8*i+:8], 1'b1, r);
    endtask
    task rbyte(input string name, input logic [7:0] exp);
        fsr_host_inst.xbyte(8'h00, 1'b0, r);
        check(name, r, exp);
    endtask
    task wait_idle();
        for (int i = 0; i < 2000 && status[0] !== 1'b0; i++) begin
            @(negedge clk_i);
        end
    endtask
    task t_latch();
        check("status_rst", status, 16'h0000);
        send(8'h06);
        check("wel_set", status[1], 1'b1);
        reset_i = 1'b1;
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        check("wel_reset", status, 16'h0000);
        send(8'h06);
        ext_done_i = 1'b1;
        @(negedge clk_i);
        ext_done_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check("wel_done", status[1], 1'b0);
        send(8'h06);
        send(8'h04);
        check("wel_clr", status[1], 1'b0);
        fsr_host_inst.sel();
        fsr_host_inst.xbyte(8'h06, 1'b1, r);
        fsr_host_inst.xbyte(8'h00, 1'b1, r);
        fsr_host_inst.desel();
        check("wel_long", status[1], 1'b0);
    endtask
    task t_vol();
        send(8'h50);
        check("vol_wel", status[1], 1'b0);
        swr(2, 16'h0C55);
        check("vol_wr", status, 16'h0854);
        swr(2, 16'hFFFF);
        check("no_wel", status, 16'h0854);
    endtask
    task t_sread();
        send(8'h06);
        rd(8'h05, 24'h000000);
        check("st_lo", r, 8'h56);
        rbyte("st_lo_rep", 8'h56);
        fsr_host_inst.desel();
        fsr_host_inst.sel();
        fsr_host_inst.xbyte(8'h35, 1'b1, r);
        rbyte("st_hi", 8'h08);
        rbyte("st_hi_rep", 8'h08);
        fsr_host_inst.desel();
    endtask
    task t_swr();
        swr(2, 16'hFFFF);
        check("wr16", status, 16'h79FF);
        fsr_host_inst.sel();
        fsr_host_inst.xbyte(8'h05, 1'b1, r);
        rbyte("st_busy", 8'hFF);
        fsr_host_inst.desel();
        send(8'h04);
        check("write_disable_cmd_busy", status[1], 1'b1);
        wait_idle();
        check("wr16_end", status, 16'h79FC);
        send(8'h06);
        swr(1, 16'h0000);
        check("wr8", status, 16'h3903);
        wait_idle();
        send(8'h06);
        swr(3, 16'h00AA);
        check("wr24", status, 16'h3902);
        send(8'h04);
    endtask
    task t_read();
        rd(8'h03, 24'h0000FE);
        for (int k = 0; k < 3; k++) rbyte("rd", (8'hFE + k) ^ 8'hA5);
        fsr_host_inst.desel();
        ext_busy_i = 1'b1;
        rd(8'h03, 24'h000010);
        // Undriven line floats to the inverse of the host's last zero.
        rbyte("rd_busy", 8'hFF);
        fsr_host_inst.desel();
        check("rd_busy_oe", fsr_host_inst.oe_seen, 1'b0);
        ext_busy_i = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
    task t_fast();
        rd(8'h0B, 24'h123456);
        fsr_host_inst.xbyte(8'h00, 1'b1, r);
        rbyte("fast", 8'h56 ^ 8'hA5);
        fsr_host_inst.desel();
        quad_mode_i = 1'b1;
        for (int d = 0; d < 4; d++) begin
            dummy_count_i = d;
            slow = d[0];
            rd(8'h0B, 24'h0000F0 + d);
            fsr_host_inst.clocks(dtab[d]);
            rbyte("qfast0", (8'hF0 + d) ^ 8'hA5);
            rbyte("qfast1", (8'hF1 + d) ^ 8'hA5);
            fsr_host_inst.desel();
        end
        quad_mode_i = 1'b0;
        slow = 1'b0;
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        t_latch();
        t_vol();
        t_sread();
        t_swr();
        t_read();
        t_fast();
        close_out();
    end
    // Watchdog well past the expected run of some 5200 clocks.
    initial begin
        #240000;
        fail_count++;
        close_out();
    end
endmodule
